// ===== tbm_defs.vh
// Register map, field positions and timing constants for the temperature/battery monitor
`ifndef TBM_DEFS_VH
`define TBM_DEFS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TBM_ADDR_VCO_TEST 16'h2500
`define TBM_ADDR_LOAD 16'h2704
`define TBM_ADDR_TEMP_HIGH 16'h2881
`define TBM_ADDR_TEMP_LOW 16'h2882
`define TBM_ADDR_BATT 16'h2885
`define TBM_ADDR_CONFIG 16'h28A0
`define TBM_ADDR_TRIGGER 16'h28B4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TBM_BIT_LOAD_EN 3
`define TBM_BIT_BATT_WITH_TEMP 4
`define TBM_BIT_SUPPLY_SEL 6
`define TBM_BIT_BATT_CHOICE 7
`define TBM_BIT_PENDING 3
`define TBM_BIT_TRIGGER 6
`define TBM_PERIOD_MANUAL 3'h0
`define TBM_PERIOD_CONT 3'h7
// ----------------------------------------
// Power modes
// ----------------------------------------
`define TBM_MODE_MISSION 2'h0
`define TBM_MODE_BROWNOUT 2'h1
`define TBM_MODE_DISPLAY 2'h2
`define TBM_MODE_SLEEP 2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define TBM_CLK_MHZ 100
`define TBM_CFG_WRITE_MS 6
`define TBM_CFG_WRITE_CYC (`TBM_CFG_WRITE_MS * 1000 * `TBM_CLK_MHZ)
`define TBM_SEC_CYC (1000 * 1000 * `TBM_CLK_MHZ)
`endif

// ===== tbm_timer.v
// Countdown timer that pulses once its load value has elapsed
`default_nettype none
module tbm_timer #(
  parameter W = 32
) (
  input wire core_clk,
  input wire resetn,
  input wire start,
  input wire [W-1:0] load,
  output reg busy,
  output reg done
);
  reg [W-1:0] count;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= load;
        busy <= 1'b1;
      end else if (busy) begin
        if (count <= {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tbm_period.v
// Periodic measurement tick generator, 2^(3+n) seconds for n of 1 to 6; no tick when n is 0 or 7
`default_nettype none
module tbm_period #(
  parameter [31:0] SEC_CYC = 32'd100000000
) (
  input wire core_clk,
  input wire resetn,
  input wire [2:0] period,
  output reg tick
);
  reg [31:0] sec_count;
  reg [9:0] sec_total;
  wire sec_pulse = (sec_count == SEC_CYC - 32'd1);
  wire [9:0] span = 10'h001 << (3 + period);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sec_count <= 32'h0;
      sec_total <= 10'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (period == 3'h0 || period == 3'h7) begin
        sec_count <= 32'h0;
        sec_total <= 10'h0;
      end else if (sec_pulse) begin
        sec_count <= 32'h0;
        if (sec_total + 10'h1 >= span) begin
          sec_total <= 10'h0;
          tick <= 1'b1;
        end else begin
          sec_total <= sec_total + 10'h1;
        end
      end else begin
        sec_count <= sec_count + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tbm_ctrl.v
// Temperature sensor and battery monitor control and readout
`include "tbm_defs.vh"
`default_nettype none
module tbm_ctrl #(
  parameter [31:0] CFG_WRITE_CYC = `TBM_CFG_WRITE_CYC,
  parameter [31:0] SEC_CYC = `TBM_SEC_CYC
) (
  input wire core_clk,
  input wire resetn,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [1:0] power_mode,
  output reg sensor_enable,
  input wire sensor_done,
  input wire [10:0] sensor_temp,
  input wire [7:0] sensor_batt,
  output reg batt_measure,
  output reg supply_from_digital,
  output reg batt_select_main,
  output reg load_on_main,
  output reg load_on_clock_batt,
  output reg vco_run
);
  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  reg [7:0] cfg_byte;
  reg [7:0] cfg_staged;
  reg [1:0] vco_test_select;
  reg battery_load_enable;
  reg sense_trigger;
  reg [10:0] temperature_result;
  reg [7:0] battery_result;
  reg meas_active;
  reg meas_with_batt;
  wire cfg_timer_busy;
  wire cfg_done;
  // Pending covers the commit cycle too, so a read never shows the old byte as settled
  wire cfg_pending = cfg_timer_busy || cfg_done;
  wire period_tick;
  wire [2:0] period = cfg_byte[2:0];
  wire quiet_mode = (power_mode == `TBM_MODE_SLEEP) || (power_mode == `TBM_MODE_DISPLAY);
  wire wr_cfg = reg_wr && reg_addr == `TBM_ADDR_CONFIG && !cfg_pending;
  wire wr_trig = reg_wr && reg_addr == `TBM_ADDR_TRIGGER;
  wire trig_start = wr_trig && reg_wdata[`TBM_BIT_TRIGGER] && !sense_trigger
    && period == `TBM_PERIOD_MANUAL && !quiet_mode;
  wire auto_start = (period_tick || period == `TBM_PERIOD_CONT) && !meas_active;
  wire start_meas = !meas_active && (trig_start || auto_start);

  // ----------------------------------------
  // Slow config write model and period timer
  // ----------------------------------------
  // The config byte commits only after the full write time, like the real storage.
  tbm_timer #(.W(32)) u_cfg_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(wr_cfg),
    .load(CFG_WRITE_CYC),
    .busy(cfg_timer_busy),
    .done(cfg_done)
  );
  tbm_period #(.SEC_CYC(SEC_CYC)) u_period (
    .core_clk(core_clk),
    .resetn(resetn),
    .period(period),
    .tick(period_tick)
  );

  // ----------------------------------------
  // Register writes and measurement sequencing
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_byte <= 8'h00;
      cfg_staged <= 8'h00;
      vco_test_select <= 2'h0;
      battery_load_enable <= 1'b0;
      sense_trigger <= 1'b0;
      temperature_result <= 11'h000;
      battery_result <= 8'h00;
      meas_active <= 1'b0;
      meas_with_batt <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_staged <= reg_wdata;
      end
      if (cfg_done) begin
        cfg_byte <= {cfg_staged[7:4], 1'b0, cfg_staged[2:0]};
      end
      if (reg_wr && reg_addr == `TBM_ADDR_VCO_TEST) begin
        vco_test_select <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == `TBM_ADDR_LOAD) begin
        battery_load_enable <= reg_wdata[`TBM_BIT_LOAD_EN];
      end
      if (start_meas) begin
        meas_active <= 1'b1;
        meas_with_batt <= cfg_byte[`TBM_BIT_BATT_WITH_TEMP];
        if (trig_start) begin
          sense_trigger <= 1'b1;
        end
      end else if (meas_active && sensor_done) begin
        meas_active <= 1'b0;
        temperature_result <= sensor_temp;
        if (meas_with_batt) begin
          battery_result <= sensor_batt;
        end
        sense_trigger <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sensor_enable <= 1'b0;
      batt_measure <= 1'b0;
      supply_from_digital <= 1'b0;
      batt_select_main <= 1'b0;
      load_on_main <= 1'b0;
      load_on_clock_batt <= 1'b0;
      vco_run <= 1'b0;
    end else begin
      sensor_enable <= start_meas || (meas_active && !sensor_done);
      batt_measure <= (start_meas ? cfg_byte[`TBM_BIT_BATT_WITH_TEMP] : meas_with_batt)
        && (start_meas || (meas_active && !sensor_done));
      supply_from_digital <= cfg_byte[`TBM_BIT_SUPPLY_SEL] && !quiet_mode;
      batt_select_main <= cfg_byte[`TBM_BIT_BATT_CHOICE];
      load_on_main <= battery_load_enable && power_mode == `TBM_MODE_MISSION
        && cfg_byte[`TBM_BIT_BATT_CHOICE];
      load_on_clock_batt <= battery_load_enable && power_mode == `TBM_MODE_MISSION
        && !cfg_byte[`TBM_BIT_BATT_CHOICE];
      vco_run <= |vco_test_select;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Reads settle one cycle after the read strobe; unmapped addresses read zero.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TBM_ADDR_VCO_TEST: reg_rdata <= {6'h00, vco_test_select};
        `TBM_ADDR_LOAD: reg_rdata <= {4'h0, battery_load_enable, 3'h0};
        `TBM_ADDR_TEMP_HIGH: reg_rdata <= temperature_result[10:3];
        `TBM_ADDR_TEMP_LOW: reg_rdata <= {temperature_result[2:0], 5'h00};
        `TBM_ADDR_BATT: reg_rdata <= battery_result;
        `TBM_ADDR_CONFIG: reg_rdata <= {cfg_byte[7:4], cfg_pending, cfg_byte[2:0]};
        `TBM_ADDR_TRIGGER: reg_rdata <= {1'b0, sense_trigger, 6'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tbm_ctrl_monitor.sv
// Port checker for the temperature and battery monitor
`include "tbm_defs.vh"
`default_nettype none
module tbm_ctrl_monitor (
  input wire logic core_clk, resetn, reg_wr, reg_rd, sensor_enable, sensor_done,
  input wire logic batt_measure, supply_from_digital, batt_select_main, load_on_main,
  input wire logic load_on_clock_batt, vco_run,
  input wire logic [1:0] power_mode,
  input wire logic [7:0] reg_wdata, reg_rdata, sensor_batt,
  input wire logic [10:0] sensor_temp,
  input wire logic [15:0] reg_addr
);
  logic [10:0] t_seen;
  logic [7:0] b_seen;
  wire logic fin = sensor_done && sensor_enable;
  // Shadow of the last results, so reads can be tied to the sensor
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      t_seen <= 11'h000;
      b_seen <= 8'h00;
    end else if (fin) begin
      t_seen <= sensor_temp;
      b_seen <= batt_measure ? sensor_batt : b_seen;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_vco_runs: assert property (reg_wr && reg_addr == `TBM_ADDR_VCO_TEST
    && |reg_wdata[1:0] |-> ##[1:2] vco_run) else $error("vco idle");
  chk_load_mission: assert property (load_on_main || load_on_clock_batt
    |-> $past(power_mode) == `TBM_MODE_MISSION) else $error("load out of mission");
  chk_load_side: assert property (load_on_main |-> batt_select_main)
    else $error("load on wrong battery");
  chk_supply_sel: assert property (supply_from_digital |-> !$past(power_mode[1]))
    else $error("rail supply in low power");
  chk_batt_meas: assert property (batt_measure |-> sensor_enable)
    else $error("stray battery reading");
  chk_meas_ends: assert property (fin |=> !sensor_enable)
    else $error("measurement kept on");
  chk_temp_read: assert property (reg_rd && !fin && reg_addr == `TBM_ADDR_TEMP_HIGH
    |=> reg_rdata == t_seen[10:3]) else $error("temperature byte wrong");
  chk_batt_read: assert property (reg_rd && !fin && reg_addr == `TBM_ADDR_BATT
    |=> reg_rdata == b_seen) else $error("battery byte wrong");
  cover property (fin && batt_measure);
  cover property (load_on_main);
  cover property (reg_wr && reg_addr == `TBM_ADDR_TRIGGER && power_mode[1]);
endmodule
bind tbm_ctrl tbm_ctrl_monitor tbm_ctrl_monitor_inst (.*);
`default_nettype wire

// ===== tbm_sensor_model.sv
// Behavioural model of the analog sensor front end
`default_nettype none
module tbm_sensor_model (
  input wire logic core_clk, sensor_enable, batt_measure,
  input wire logic [7:0] dly, bv,
  input wire logic [10:0] tv,
  output logic sensor_done,
  output logic [10:0] sensor_temp,
  output logic [7:0] sensor_batt
);
  logic [7:0] cnt;
  always @(posedge core_clk) begin
    cnt <= sensor_enable && !sensor_done ? cnt + 8'h01 : 8'h00;
    sensor_done <= sensor_enable && !sensor_done && cnt == dly;
  end
  // Inverted outside the done cycle, so a late sample never looks right
  assign sensor_temp = sensor_done ? tv : ~tv;
  assign sensor_batt = sensor_done && batt_measure ? bv : ~bv;
endmodule
`default_nettype wire

// ===== test_tbm_ctrl.sv
// Self-checking testbench for the temperature and battery monitor
`include "tbm_defs.vh"
`default_nettype none
module test_tbm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = '0, resetn = '0, reg_wr = '0, reg_rd = '0;
  logic [1:0] power_mode = '0;
  logic [7:0] reg_wdata = '0, dly = '0, bv = '0, rd_val, c, ob;
  logic [10:0] tv = '0, t;
  logic [15:0] reg_addr = '0, cf = `TBM_ADDR_CONFIG, tg = `TBM_ADDR_TRIGGER;
  wire logic [7:0] reg_rdata, sensor_batt;
  wire logic [10:0] sensor_temp;
  wire logic sensor_enable, sensor_done, batt_measure, supply_from_digital, batt_select_main;
  wire logic load_on_main, load_on_clock_batt, vco_run;
  int bad_count = 0, total_checks = 0, n;
  initial forever #5 core_clk = ~core_clk;
  // Short counts keep config writes and the shortest period within a few hundred cycles
  tbm_ctrl #(.CFG_WRITE_CYC(32'h14), .SEC_CYC(32'hA)) tbm_ctrl_inst (.*);
  tbm_sensor_model tbm_sensor_model_inst (.*);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    rd_val = reg_rdata;
  endtask
  task automatic poll(input logic [15:0] a, input int b);
    for (int k = 0; k < 300; k++) begin
      rd(a);
      if (rd_val[b] === 1'b0) return;
    end
    chk(11'h000, 11'h001);
    end_of_test();
  endtask
  initial begin
    void'($urandom(32'hEF15));
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    rd(cf);
    chk(11'h000, rd_val);
    rd(16'h2600);
    chk(11'h000, rd_val);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      c = ($urandom & 8'hC0) | (i < 5 ? 8'h10 : 8'h00);
      tv = i == 0 ? 11'h400 : i == 1 ? 11'h3FF : 11'($urandom);
      bv = 8'($urandom);
      dly = 8'($urandom_range(30));
      power_mode = {1'b0, i[0]};
      wr(cf, c);
      poll(cf, 3);
      chk({c[7], c[6]}, {batt_select_main, supply_from_digital});
      wr(tg, 8'h40);
      poll(tg, 6);
      rd(`TBM_ADDR_TEMP_HIGH);
      t = {3'h0, rd_val} << 3;
      rd(`TBM_ADDR_TEMP_LOW);
      chk(tv, t | ({3'h0, rd_val} >> 5));
      rd(`TBM_ADDR_BATT);
      ob = c[4] ? bv : ob;
      chk(ob, rd_val);
    end
    $display("manual test done");
    wr(cf, 8'hC0);
    poll(cf, 3);
    wr(`TBM_ADDR_LOAD, 8'h08);
    for (int m = 0; m < 4; m++) begin
      power_mode = 2'(m);
      wr(`TBM_ADDR_VCO_TEST, 8'(m));
      wr(tg, {1'b0, m > 1, 6'h00});
      repeat (3) @(negedge core_clk);
      chk({m == 0, 1'b0, m < 2, m != 0, 1'b0},
        {load_on_main, load_on_clock_batt, supply_from_digital, vco_run, sensor_enable});
      rd(tg);
      chk(11'h000, rd_val[6]);
    end
    power_mode = 2'h0;
    wr(cf, 8'h00);
    poll(cf, 3);
    chk(11'h001, {load_on_main, load_on_clock_batt});
    wr(`TBM_ADDR_LOAD, 8'h00);
    $display("mode test done");
    wr(cf, 8'h01);
    wr(cf, 8'h07);
    poll(cf, 3);
    chk(11'h001, rd_val);
    wr(tg, 8'h40);
    n = 0;
    while (sensor_enable !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    // Early start means the trigger was taken, late means a wrong period
    chk(11'h001, n > 100 && n < 185);
    dly = 8'h00;
    wr(cf, 8'h07);
    poll(cf, 3);
    n = 0;
    repeat (60) begin
      @(negedge core_clk);
      n += sensor_done;
    end
    chk(11'h001, n > 8);
    $display("period test done");
    end_of_test();
  end
endmodule
`default_nettype wire
